// ===== logic/sie_pkg.sv
package sie_pkg;
  // ****************************************
  // lamp colour codes
  // ****************************************
  typedef enum logic [1:0] {
    SIE_OFF = 2'h0,
    SIE_GREEN = 2'h1,
    SIE_RED = 2'h2,
    SIE_YELLOW = 2'h3
  } sie_colour_t;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int ACT_HOLD_MS = 100;
  localparam int ACT_HOLD_CYC = CLK_HZ / 1000 * ACT_HOLD_MS;
  localparam int CNT_W = 32;
endpackage

// ===== logic/sie_sync.sv
`timescale 1ns/100ps
module sie_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] s2_next;
  always_comb begin
    s1_next = d;
    s2_next = s1_reg;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  assign q = s2_reg;
endmodule

// ===== logic/sie_link_lamp.sv
`timescale 1ns/100ps
module sie_link_lamp (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // timing
  input wire logic flash_phase,
  input wire logic [31:0] hold_cycles,
  // link state, already synchronised
  input wire logic link_up,
  input wire logic activity,
  // lamp
  output logic [1:0] lamp
);
  logic [31:0] hold_reg;
  logic [31:0] hold_next;
  logic [1:0] lamp_reg;
  logic [1:0] lamp_next;
  always_comb begin
    hold_next = hold_reg;
    if (activity && link_up) begin
      hold_next = hold_cycles;
    end else if (hold_reg != 32'h0) begin
      hold_next = hold_reg - 32'h1;
    end
    if (!link_up) begin
      lamp_next = sie_pkg::SIE_OFF;
    end else if (hold_reg != 32'h0) begin
      lamp_next = flash_phase ? sie_pkg::SIE_GREEN : sie_pkg::SIE_OFF;
    end else begin
      lamp_next = sie_pkg::SIE_GREEN;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= 32'h0;
      lamp_reg <= 2'h0;
    end else begin
      hold_reg <= hold_next;
      lamp_reg <= lamp_next;
    end
  end
  assign lamp = lamp_reg;
endmodule

// ===== logic/sie_encoder.sv
`timescale 1ns/100ps
module sie_encoder #(
  parameter int N_TEST = 4,
  parameter logic [31:0] FLASH_HALF = 32'(sie_pkg::FLASH_HALF_CYC),
  parameter logic [31:0] ACT_HOLD = 32'(sie_pkg::ACT_HOLD_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // flash period override, zero selects the default half period
  input wire logic [31:0] flash_half_cycles,
  // module condition inputs from pins
  input wire logic power_ok,
  input wire logic unrecoverable_fault,
  input wire logic recoverable_fault,
  input wire logic config_invalid,
  input wire logic self_test,
  input wire logic fw_update,
  input wire logic idle_wait,
  // network condition inputs
  input wire logic ip_acquired,
  input wire logic conn_established,
  input wire logic conn_timeout,
  input wire logic critical_link_fail,
  input wire logic await_target_network_identifier,
  // link ports
  input wire logic [1:0] link_up,
  input wire logic [1:0] link_activity,
  // test outputs
  input wire logic [N_TEST-1:0] test_on,
  input wire logic [N_TEST-1:0] test_unused,
  input wire logic [N_TEST-1:0] test_fault,
  // lamps: 2-bit colour codes
  output logic [1:0] health_lamp,
  output logic [1:0] net_lamp,
  output logic [1:0] link0_lamp,
  output logic [1:0] link1_lamp,
  output logic [2*N_TEST-1:0] test_lamp
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NS = 12 + 4 + 3 * N_TEST;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  assign raw = {power_ok, unrecoverable_fault, recoverable_fault,
                config_invalid, self_test, fw_update, idle_wait,
                ip_acquired, conn_established, conn_timeout,
                critical_link_fail, await_target_network_identifier,
                link_up, link_activity, test_on, test_unused, test_fault};
  sie_sync #(.W(NS)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(raw),
    .q(syn)
  );
  logic s_pwr;
  logic s_unrec;
  logic s_rec;
  logic s_cfg;
  logic s_st;
  logic s_fw;
  logic s_idle;
  logic s_ip;
  logic s_est;
  logic s_tmo;
  logic s_crit;
  logic s_tgt;
  logic [1:0] s_lup;
  logic [1:0] s_lact;
  logic [N_TEST-1:0] s_ton;
  logic [N_TEST-1:0] s_tun;
  logic [N_TEST-1:0] s_tflt;
  assign {s_pwr, s_unrec, s_rec, s_cfg, s_st, s_fw, s_idle, s_ip, s_est,
          s_tmo, s_crit, s_tgt, s_lup, s_lact, s_ton, s_tun, s_tflt} = syn;
  // ****************************************
  // shared flash timebase
  // ****************************************
  logic [31:0] half_sel;
  logic [31:0] fcnt_reg;
  logic [31:0] fcnt_next;
  logic phase_reg;
  logic phase_next;
  always_comb begin
    half_sel = (flash_half_cycles == 32'h0) ? FLASH_HALF : flash_half_cycles;
    fcnt_next = fcnt_reg + 32'h1;
    phase_next = phase_reg;
    if (fcnt_reg >= half_sel - 32'h1) begin
      fcnt_next = 32'h0;
      phase_next = !phase_reg;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fcnt_reg <= 32'h0;
      phase_reg <= 1'b0;
    end else begin
      fcnt_reg <= fcnt_next;
      phase_reg <= phase_next;
    end
  end
  // ****************************************
  // unrecoverable fault latch
  // ****************************************
  logic unrec_reg;
  logic unrec_next;
  always_comb begin
    unrec_next = (unrec_reg || s_unrec) && s_pwr;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unrec_reg <= 1'b0;
    end else begin
      unrec_reg <= unrec_next;
    end
  end
  // ****************************************
  // health and network lamps
  // ****************************************
  logic [1:0] flash_g;
  logic [1:0] flash_r;
  logic [1:0] alt_rg;
  logic [1:0] health_reg;
  logic [1:0] health_next;
  logic [1:0] net_reg;
  logic [1:0] net_next;
  always_comb begin
    flash_g = phase_reg ? sie_pkg::SIE_GREEN : sie_pkg::SIE_OFF;
    flash_r = phase_reg ? sie_pkg::SIE_RED : sie_pkg::SIE_OFF;
    alt_rg = phase_reg ? sie_pkg::SIE_RED : sie_pkg::SIE_GREEN;
    // fixed precedence, highest first
    if (!s_pwr) begin
      health_next = sie_pkg::SIE_OFF;
    end else if (unrec_reg || s_unrec) begin
      health_next = sie_pkg::SIE_RED;
    end else if (s_st) begin
      health_next = alt_rg;
    end else if (s_fw) begin
      health_next = flash_r;
    end else if (s_rec) begin
      health_next = flash_r;
    end else if (s_cfg) begin
      health_next = alt_rg;
    end else if (s_idle) begin
      health_next = flash_g;
    end else begin
      health_next = sie_pkg::SIE_GREEN;
    end
    if (!s_pwr) begin
      net_next = sie_pkg::SIE_OFF;
    end else if (s_st) begin
      net_next = alt_rg;
    end else if (s_fw) begin
      net_next = flash_r;
    end else if (s_crit) begin
      net_next = sie_pkg::SIE_RED;
    end else if (s_tgt) begin
      net_next = alt_rg;
    end else if (!s_ip) begin
      net_next = sie_pkg::SIE_OFF;
    end else if (s_tmo) begin
      net_next = flash_r;
    end else if (s_est) begin
      net_next = sie_pkg::SIE_GREEN;
    end else begin
      net_next = flash_g;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      health_reg <= 2'h0;
      net_reg <= 2'h0;
    end else begin
      health_reg <= health_next;
      net_reg <= net_next;
    end
  end
  assign health_lamp = health_reg;
  assign net_lamp = net_reg;
  // ****************************************
  // link lamps
  // ****************************************
  sie_link_lamp u_link0 (
    .clk(clk),
    .reset_n(reset_n),
    .flash_phase(phase_reg),
    .hold_cycles(ACT_HOLD),
    .link_up(s_lup[0]),
    .activity(s_lact[0]),
    .lamp(link0_lamp)
  );
  sie_link_lamp u_link1 (
    .clk(clk),
    .reset_n(reset_n),
    .flash_phase(phase_reg),
    .hold_cycles(ACT_HOLD),
    .link_up(s_lup[1]),
    .activity(s_lact[1]),
    .lamp(link1_lamp)
  );
  // ****************************************
  // test-output lamps
  // ****************************************
  logic [2*N_TEST-1:0] test_reg;
  logic [2*N_TEST-1:0] test_next;
  always_comb begin
    test_next = '0;
    for (int i = 0; i < N_TEST; i++) begin
      if (!s_pwr || s_tun[i]) begin
        test_next[2*i +: 2] = sie_pkg::SIE_OFF;
      end else if (s_tflt[i]) begin
        test_next[2*i +: 2] = sie_pkg::SIE_RED;
      end else if (s_ton[i]) begin
        test_next[2*i +: 2] = sie_pkg::SIE_YELLOW;
      end else begin
        test_next[2*i +: 2] = sie_pkg::SIE_OFF;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_reg <= '0;
    end else begin
      test_reg <= test_next;
    end
  end
  assign test_lamp = test_reg;
endmodule

// ===== dv/sie_lamp_view.sv
`timescale 1ns/100ps
module sie_lamp_view (
  // clock and window control
  input wire logic clk,
  input wire logic clr,
  // lamp colour and colours seen
  input wire logic [1:0] lamp,
  output logic [3:0] seen
);
  // ****
  // one bit per colour shown since clr fell
  // ****
  always_ff @(posedge clk) begin
    if (clr) begin
      seen <= 4'h0;
    end else begin
      seen <= seen | (4'h1 << lamp);
    end
  end
endmodule

// ===== dv/sie_encoder_monitor.sv
`timescale 1ns/100ps
module sie_encoder_monitor #(
  parameter int N_TEST = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // conditions
  input wire logic power_ok,
  input wire logic unrecoverable_fault,
  input wire logic self_test,
  input wire logic fw_update,
  input wire logic ip_acquired,
  input wire logic conn_established,
  input wire logic conn_timeout,
  input wire logic critical_link_fail,
  input wire logic await_target_network_identifier,
  input wire logic [1:0] link_up,
  input wire logic [N_TEST-1:0] test_on,
  input wire logic [N_TEST-1:0] test_unused,
  input wire logic [N_TEST-1:0] test_fault,
  // lamps
  input wire logic [1:0] health_lamp,
  input wire logic [1:0] net_lamp,
  input wire logic [1:0] link0_lamp,
  input wire logic [2*N_TEST-1:0] test_lamp
);
  // ****
  // lamp checks, three edges after the cause
  // ****
  logic plain;
  assign plain = power_ok && !self_test && !fw_update &&
    !critical_link_fail && !await_target_network_identifier;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_dark_no_power: assert property (!power_ok |-> ##3
    health_lamp == 2'h0 && net_lamp == 2'h0) else $error("lamp lit");
  chk_health_red: assert property (power_ok && unrecoverable_fault
    |-> ##3 health_lamp == 2'h2) else $error("health not red");
  chk_selftest_alt: assert property (power_ok && self_test |-> ##3
    net_lamp inside {2'h1, 2'h2}) else $error("net not alternating");
  chk_update_flash: assert property (power_ok && fw_update
    && !self_test |-> ##3 net_lamp inside {2'h0, 2'h2})
    else $error("net not red flash");
  chk_crit_red: assert property (power_ok && critical_link_fail
    && !self_test && !fw_update |-> ##3 net_lamp == 2'h2)
    else $error("net not red");
  chk_no_ip_dark: assert property (plain && !ip_acquired |-> ##3
    net_lamp == 2'h0) else $error("net lit without address");
  chk_est_green: assert property (plain && ip_acquired
    && conn_established && !conn_timeout |-> ##3 net_lamp == 2'h1)
    else $error("net not green");
  chk_timeout_flash: assert property (plain && ip_acquired
    && conn_timeout |-> ##3 net_lamp inside {2'h0, 2'h2})
    else $error("net not red flash");
  chk_link_dark: assert property (!link_up[0] |-> ##3
    link0_lamp == 2'h0) else $error("link lamp lit");
  chk_test_yellow: assert property (power_ok && test_on[0]
    && !test_unused[0] && !test_fault[0] |-> ##3 test_lamp[1:0] == 2'h3)
    else $error("test lamp not yellow");
  chk_test_red: assert property (power_ok && test_fault[2]
    && !test_unused[2] |-> ##3 test_lamp[5:4] == 2'h2)
    else $error("test lamp not red");
endmodule
bind sie_encoder sie_encoder_monitor #(.N_TEST(N_TEST))
  sie_encoder_monitor_inst (.*);

// ===== dv/sie_encoder_tb_top.sv
`timescale 1ns/100ps
module sie_encoder_tb_top;
  // ****
  // stimulus, lamps and expected colour sets
  // ****
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clr = 1'b1;
  logic [11:0] c = 12'h000;
  logic [1:0] up = 2'h0;
  logic [1:0] act = 2'h0;
  logic [3:0] t_on = 4'h0;
  logic [3:0] t_unu = 4'h0;
  logic [3:0] t_flt = 4'h0;
  wire [15:0] lamps;
  wire [3:0] seen [8];
  int n_fail = 0;
  int checked = 0;
  localparam logic [11:0] CV [13] = '{12'h090, 12'h001, 12'h011, 12'h021,
    12'h005, 12'h009, 12'h041, 12'h081, 12'h181, 12'h381, 12'h581,
    12'h881, 12'h029};
  localparam logic [7:0] EX [13] = '{8'h11, 8'h21, 8'h66, 8'h55, 8'h51,
    8'h61, 8'h31, 8'h23, 8'h22, 8'h25, 8'h24, 8'h26, 8'h55};
  initial begin
    forever #12.5 clk = ~clk;
  end
  sie_encoder #(.ACT_HOLD(32'h8)) sie_encoder_inst (.clk(clk),
    .reset_n(reset_n), .flash_half_cycles(32'h4), .power_ok(c[0]),
    .unrecoverable_fault(c[1]), .recoverable_fault(c[2]),
    .config_invalid(c[3]), .self_test(c[4]), .fw_update(c[5]),
    .idle_wait(c[6]), .ip_acquired(c[7]), .conn_established(c[8]),
    .conn_timeout(c[9]), .critical_link_fail(c[10]),
    .await_target_network_identifier(c[11]), .link_up(up),
    .link_activity(act), .test_on(t_on), .test_unused(t_unu),
    .test_fault(t_flt), .health_lamp(lamps[1:0]), .net_lamp(lamps[3:2]),
    .link0_lamp(lamps[5:4]), .link1_lamp(lamps[7:6]),
    .test_lamp(lamps[15:8]));
  for (genvar i = 0; i < 8; i++) begin : g_view
    sie_lamp_view sie_lamp_view_inst (.clk(clk), .clr(clr),
      .lamp(lamps[2*i+:2]), .seen(seen[i]));
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [11:0] cv);
    @(posedge clk);
    #2 c = cv;
    repeat (14) @(posedge clk);
    #2 clr = 1'b0;
    repeat (16) @(posedge clk);
    #2 clr = 1'b1;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #2 reset_n = 1'b1;
    for (int i = 0; i < 13; i++) begin
      run(CV[i]);
      chk(16'(seen[0]),
        16'(EX[i][7:4]));
      chk(16'(seen[1]),
        16'(EX[i][3:0]));
    end
    run(12'h003);
    chk(16'(seen[0]), 16'h4);
    run(12'h001);
    chk(16'(seen[0]), 16'h4);
    @(posedge clk);
    #2 reset_n = 1'b0;
    #1 chk(lamps, 16'h0000);
    @(posedge clk);
    #2 reset_n = 1'b1;
    run(12'h001);
    chk(16'(seen[0]), 16'h2);
    up = 2'b11;
    act = 2'b01;
    t_on = 4'b0011;
    t_unu = 4'b0010;
    t_flt = 4'b0100;
    run(12'h001);
    for (int i = 2; i < 8; i++) begin
      chk(16'(seen[i]),
        16'(32'h14182300 >> (4 * i)) & 16'hF);
    end
    up = 2'b01;
    act = 2'b00;
    run(12'h001);
    chk(16'(seen[2]), 16'h2);
    chk(16'(seen[3]), 16'h1);
    run(12'h000);
    chk(16'(seen[4]), 16'h1);
    summarize();
  end
endmodule
